// ==== src/wake_cfg_pkg.sv ====
package wake_cfg_pkg;

   // ---------------------------------------------------------------
   // Frame command codes (frame bits 15..9)
   // ---------------------------------------------------------------
   localparam logic [6:0] CMD_WR_WAKE = 7'h45;
   localparam logic [6:0] CMD_WR_IRQ = 7'h46;
   localparam logic [6:0] CMD_RD_WAKE = 7'h05;
   localparam logic [6:0] CMD_RD_IRQ = 7'h06;
   localparam int FRAME_BITS = 16;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int WAKE_L3_LSB = 6;
   localparam int WAKE_L4_LSB = 4;
   localparam int WAKE_L5_LSB = 2;
   localparam int MASK_IO23_BIT = 1;
   localparam int MASK_IO45_BIT = 0;
   localparam int IRQ_DUR_BIT = 7;
   localparam int IRQ_LIN_BIT = 6;
   localparam int IRQ_ALL_BIT = 5;
   localparam int IRQ_VSNS_BIT = 4;
   localparam int IRQ_VPRE_BIT = 3;
   localparam int IRQ_VCORE_BIT = 2;
   localparam int IRQ_VOTH_BIT = 1;
   localparam int IRQ_CAN_BIT = 0;
   localparam int FLAG_SERIAL_BIT = 7;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] WAKE_CFG_RST = 8'h00;
   localparam logic [7:0] IRQ_CFG_RST = 8'h00;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int PULSE_LONG_NS = 100000;
   localparam int PULSE_SHORT_NS = 25000;
   localparam int PULSE_LONG_CYC = PULSE_LONG_NS / CLK_PERIOD_NS;
   localparam int PULSE_SHORT_CYC = PULSE_SHORT_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      WAKE_NONE = 2'b00,
      WAKE_RISE = 2'b01,
      WAKE_FALL = 2'b10,
      WAKE_ANY = 2'b11
   } wake_edge_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CHECK = 2'b01,
      ST_COMMIT = 2'b11
   } ctl_state_e;

   typedef struct packed {
      logic [6:0] cmd;
      logic parity;
      logic [7:0] data;
   } spi_frame_s;

   typedef struct packed {
      logic lin;
      logic vsns;
      logic vpre;
      logic vcore;
      logic vothers;
      logic can;
   } irq_src_s;

endpackage : wake_cfg_pkg

// ==== src/pin_sync.sv ====
`timescale 1ns/10ps
module pin_sync
   import wake_cfg_pkg::*;
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] q_ff;
   logic [W-1:0] nxt_q;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s1_ff <= RST_VAL;
         s2_ff <= RST_VAL;
         s3_ff <= RST_VAL;
      end
      else
      begin
         s1_ff <= d_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // A bit moves only once the second and third stages agree
   assign nxt_q = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & q_ff);

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         q_ff <= RST_VAL;
      else
         q_ff <= nxt_q;
   end

   assign q_o = q_ff;

endmodule : pin_sync

// ==== src/spi_frame_link.sv ====
`timescale 1ns/10ps
module spi_frame_link
   import wake_cfg_pkg::*;
(
   input wire logic spi_sck_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   input wire logic rst_i,
   input wire logic [7:0] flags_i,
   input wire logic [7:0] wake_cfg_i,
   input wire logic [7:0] irq_cfg_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_n_o,
   output spi_frame_s frame_o,
   output logic frame_tgl_o
);

   logic [4:0] cnt_ff;
   logic [14:0] sh_ff;
   logic out_ff;
   logic [1:0] sel_ff;
   spi_frame_s frame_ff;
   logic tgl_ff;
   logic [3:0] idx;
   logic [2:0] addr;

   // ---------------------------------------------------------------
   // Receive on rising edge, frame state cleared while deselected
   // ---------------------------------------------------------------
   always_ff @(posedge spi_sck_i or posedge spi_cs_n_i)
   begin
      if (spi_cs_n_i)
      begin
         cnt_ff <= 5'h00;
         sh_ff <= 15'h0000;
      end
      else
      begin
         sh_ff <= {sh_ff[13:0], spi_mosi_i};
         if (cnt_ff != 5'(FRAME_BITS))
            cnt_ff <= cnt_ff + 5'h01;
      end
   end

   // Completed word is held until the next frame's sixteenth bit
   always_ff @(posedge spi_sck_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         frame_ff <= '0;
         tgl_ff <= 1'b0;
      end
      else if (!spi_cs_n_i && cnt_ff == 5'(FRAME_BITS - 1))
      begin
         frame_ff <= {sh_ff, spi_mosi_i};
         tgl_ff <= ~tgl_ff;
      end
   end

   // ---------------------------------------------------------------
   // Transmit on falling edge
   // ---------------------------------------------------------------
   assign idx = 4'(FRAME_BITS - 1) - cnt_ff[3:0];
   // Address bits 11..9 sit just above the parity bit
   assign addr = sh_ff[3:1];

   always_ff @(negedge spi_sck_i or posedge spi_cs_n_i)
   begin
      if (spi_cs_n_i)
      begin
         out_ff <= 1'b0;
         sel_ff <= 2'b00;
      end
      else if (cnt_ff < 5'h08)
         out_ff <= flags_i[idx[2:0]];
      else if (cnt_ff == 5'h08)
      begin
         // RQ2 read answer: stored value in low byte
         case (addr)
            3'b101:
            begin
               sel_ff <= 2'b01;
               out_ff <= wake_cfg_i[7];
            end
            3'b110:
            begin
               sel_ff <= 2'b10;
               out_ff <= irq_cfg_i[7];
            end
            default:
            begin
               sel_ff <= 2'b00;
               out_ff <= 1'b0;
            end
         endcase
      end
      else if (cnt_ff < 5'(FRAME_BITS))
      begin
         case (sel_ff)
            2'b01: out_ff <= wake_cfg_i[idx[2:0]];
            2'b10: out_ff <= irq_cfg_i[idx[2:0]];
            default: out_ff <= 1'b0;
         endcase
      end
   end

   // First bit must be on the line before the first clock edge
   assign spi_miso_o = (cnt_ff == 5'h00) ? flags_i[7] : out_ff;
   assign spi_miso_oe_n_o = spi_cs_n_i;
   assign frame_o = frame_ff;
   assign frame_tgl_o = tgl_ff;

endmodule : spi_frame_link

// ==== src/wake_and_irq_mask_config.sv ====
`timescale 1ns/10ps
// Overview of operation
// RQ1: The master writes the wake-up register with command 1000101, parity in bit 8 and data below.
// RQ2: A read frame with bits 11 and 9 set returns global flags high and the wake-up settings low.
// RQ3: Bits 7 and 6 of the wake-up register hold the wake edge mode of line 3.
// RQ4: Bits 5 and 4 of the wake-up register hold the wake edge mode of line 4.
// RQ5: Bits 3 and 2 of the wake-up register hold the wake edge mode of line 5.
// RQ6: Mode 00 is no wake, 01 rising, 10 falling, 11 any edge, all reset on power-on.
// RQ7: Bit 0 set masks the interrupt of lines 4 and 5 and drops them from the group flag.
// RQ8: Bit 1 set masks the interrupt of lines 2 and 3 and drops them from the group flag.
// RQ9: Software should set the matching mask for any line used for fail-safe duty.
// RQ10: The interrupt register uses write command 1000110, read bits 11 and 10, with eight fields.
// RQ11: The pulse duration bit selects 100 us when clear and 25 us when set.
// RQ12: The LIN inhibit bit blocks interrupt requests from LIN error changes.
// RQ13: The CAN inhibit bit blocks interrupt requests from CAN error changes.
// RQ14: A write frame with bad parity leaves the register unchanged and flags a serial fault.
module wake_and_irq_mask_config
   import wake_cfg_pkg::*;
#(
   parameter int LONG_CYC = PULSE_LONG_CYC,
   parameter int SHORT_CYC = PULSE_SHORT_CYC
)
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic spi_sck_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_n_o,
   input wire logic [7:0] global_flags_i,
   input wire logic [2:0] io_level_i,
   input wire logic [3:0] io_event_i,
   input wire irq_src_s irq_src_i,
   output logic [7:0] wake_cfg_o,
   output logic [7:0] irq_cfg_o,
   output logic wake_event_o,
   output logic io_group_flag_o,
   output logic int_request_o,
   output logic [15:0] int_pulse_len_o,
   output logic serial_fault_o
);

   logic [7:0] wake_cfg_ff;
   logic [7:0] irq_cfg_ff;
   logic [7:0] snap_flags_ff;
   logic [7:0] snap_wake_ff;
   logic [7:0] snap_irq_ff;
   logic fault_ff;
   logic wake_ff;
   logic group_ff;
   logic req_ff;
   logic [15:0] len_ff;
   logic [2:0] prev_lvl_ff;
   logic tgl_seen_ff;
   spi_frame_s frame_hold_ff;
   ctl_state_e state_ff;
   ctl_state_e nxt_state;
   spi_frame_s link_frame;
   logic link_tgl;
   logic tgl_sync;
   logic cs_n_sync;
   logic [2:0] lvl_sync;
   logic frame_evt;
   logic parity_ok;
   logic is_write;
   logic [2:0] wake_hit;
   logic [3:0] io_masked;
   logic [5:0] src_vec;
   logic [5:0] src_inh;
   logic wr_wake;
   logic wr_irq;
   logic commit_go;
   logic fault_set;
   logic fault_clr;

   // ---------------------------------------------------------------
   // Serial link and crossings
   // ---------------------------------------------------------------
   spi_frame_link u_link (
      .spi_sck_i(spi_sck_i),
      .spi_cs_n_i(spi_cs_n_i),
      .spi_mosi_i(spi_mosi_i),
      .rst_i(rst_i),
      .flags_i(snap_flags_ff),
      .wake_cfg_i(snap_wake_ff),
      .irq_cfg_i(snap_irq_ff),
      .spi_miso_o(spi_miso_o),
      .spi_miso_oe_n_o(spi_miso_oe_n_o),
      .frame_o(link_frame),
      .frame_tgl_o(link_tgl)
   );

   pin_sync #(.W(2), .RST_VAL(2'b10)) u_sync_link (
      .clk_i(sys_clk_i),
      .rst_i(rst_i),
      .d_i({spi_cs_n_i, link_tgl}),
      .q_o({cs_n_sync, tgl_sync})
   );

   pin_sync #(.W(3), .RST_VAL(3'b000)) u_sync_io (
      .clk_i(sys_clk_i),
      .rst_i(rst_i),
      .d_i(io_level_i),
      .q_o(lvl_sync)
   );

   assign frame_evt = tgl_sync ^ tgl_seen_ff;

   // Snapshots stay frozen while a frame is on the wire
   // RQ2 global flags upper byte
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         snap_flags_ff <= 8'h00;
      else if (cs_n_sync)
         snap_flags_ff <= global_flags_i | {fault_ff, 7'h00};
   end

   // RQ2 stored settings lower byte
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         snap_wake_ff <= WAKE_CFG_RST;
         snap_irq_ff <= IRQ_CFG_RST;
      end
      else if (cs_n_sync)
      begin
         snap_wake_ff <= wake_cfg_ff;
         snap_irq_ff <= irq_cfg_ff;
      end
   end

   // ---------------------------------------------------------------
   // Frame decode
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tgl_seen_ff <= 1'b0;
         frame_hold_ff <= '0;
      end
      else if (frame_evt)
      begin
         tgl_seen_ff <= tgl_sync;
         frame_hold_ff <= link_frame;
      end
   end

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: if (frame_evt) nxt_state = ST_CHECK;
         ST_CHECK: nxt_state = ST_COMMIT;
         ST_COMMIT: nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         state_ff <= ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   // ---------------------------------------------------------------
   // Register commit
   // ---------------------------------------------------------------
   // RQ14 odd parity over the whole frame
   assign parity_ok = ^frame_hold_ff;
   // RQ1 wake register command
   assign wr_wake = (frame_hold_ff.cmd == CMD_WR_WAKE);
   // RQ10 interrupt register command
   assign wr_irq = (frame_hold_ff.cmd == CMD_WR_IRQ);
   assign is_write = wr_wake || wr_irq;
   assign commit_go = (state_ff == ST_COMMIT) && parity_ok;

   // RQ1 wake register write
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         wake_cfg_ff <= WAKE_CFG_RST;
      else if (commit_go && wr_wake)
         wake_cfg_ff <= frame_hold_ff.data;
   end

   // RQ10 interrupt register write
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         irq_cfg_ff <= IRQ_CFG_RST;
      else if (commit_go && wr_irq)
         irq_cfg_ff <= frame_hold_ff.data;
   end

   // ---------------------------------------------------------------
   // Serial fault
   // ---------------------------------------------------------------
   // RQ14 bad write sets, any other frame clears
   assign fault_set = (state_ff == ST_COMMIT) && is_write && !parity_ok;
   assign fault_clr = (state_ff == ST_COMMIT) && !fault_set;

   // Set is tested first so it wins over a clear
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         fault_ff <= 1'b0;
      else if (fault_set)
         fault_ff <= 1'b1;
      else if (fault_clr)
         fault_ff <= 1'b0;
   end

   // ---------------------------------------------------------------
   // Wake edge detection
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         prev_lvl_ff <= 3'b000;
      else
         prev_lvl_ff <= lvl_sync;
   end

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_wake
         wake_edge_e mode;
         // RQ3 RQ4 RQ5 field per line
         assign mode = wake_edge_e'(wake_cfg_ff[WAKE_L3_LSB - 2 * g +: 2]);
         // RQ6 edge encoding
         assign wake_hit[g] = ((mode == WAKE_RISE || mode == WAKE_ANY) &&
                               lvl_sync[g] && !prev_lvl_ff[g]) ||
                              ((mode == WAKE_FALL || mode == WAKE_ANY) &&
                               !lvl_sync[g] && prev_lvl_ff[g]);
      end
   endgenerate

   // ---------------------------------------------------------------
   // Interrupt gating
   // ---------------------------------------------------------------
   // RQ8 lines 2 and 3 masked
   assign io_masked[1:0] = io_event_i[1:0] & {2{~wake_cfg_ff[MASK_IO23_BIT]}};
   // RQ7 lines 4 and 5 masked
   assign io_masked[3:2] = io_event_i[3:2] & {2{~wake_cfg_ff[MASK_IO45_BIT]}};

   assign src_vec = irq_src_i;
   // RQ12 RQ13 per source inhibits
   assign src_inh = {irq_cfg_ff[IRQ_LIN_BIT], irq_cfg_ff[IRQ_VSNS_BIT], irq_cfg_ff[IRQ_VPRE_BIT],
                     irq_cfg_ff[IRQ_VCORE_BIT], irq_cfg_ff[IRQ_VOTH_BIT],
                     irq_cfg_ff[IRQ_CAN_BIT]};

   // Wake pulse, one cycle per enabled edge
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         wake_ff <= 1'b0;
      else
         wake_ff <= |wake_hit;
   end

   // RQ7 RQ8 group flag of unmasked lines
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         group_ff <= 1'b0;
      else
         group_ff <= |io_masked;
   end

   // RQ10 inhibit-all overrides every source
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         req_ff <= 1'b0;
      else
         req_ff <= !irq_cfg_ff[IRQ_ALL_BIT] && ((|(src_vec & ~src_inh)) || (|io_masked));
   end

   // RQ11 pulse length select
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         len_ff <= 16'(LONG_CYC);
      else
         len_ff <= irq_cfg_ff[IRQ_DUR_BIT] ? 16'(SHORT_CYC) : 16'(LONG_CYC);
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign wake_cfg_o = wake_cfg_ff;
   assign irq_cfg_o = irq_cfg_ff;
   assign wake_event_o = wake_ff;
   assign io_group_flag_o = group_ff;
   assign int_request_o = req_ff;
   assign int_pulse_len_o = len_ff;
   assign serial_fault_o = fault_ff;

endmodule : wake_and_irq_mask_config

// ==== test/wake_cfg_chk.sv ====
`timescale 1ns/10ps
module wake_cfg_chk
   import wake_cfg_pkg::*;
#(
   parameter int LONG_CYC = PULSE_LONG_CYC,
   parameter int SHORT_CYC = PULSE_SHORT_CYC
)
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_miso_oe_n_o,
   input wire logic [3:0] io_event_i,
   input wire irq_src_s irq_src_i,
   input wire logic [7:0] wake_cfg_o,
   input wire logic [7:0] irq_cfg_o,
   input wire logic wake_event_o,
   input wire logic io_group_flag_o,
   input wire logic int_request_o,
   input wire logic [15:0] int_pulse_len_o,
   input wire logic serial_fault_o
);
   // ----------------------------------------
   // Unmasked sources
   // ----------------------------------------
   logic [3:0] io_open;
   logic [5:0] src_open;
   assign io_open = io_event_i & ~{{2{wake_cfg_o[0]}}, {2{wake_cfg_o[1]}}};
   assign src_open = irq_src_i & ~{irq_cfg_o[6], irq_cfg_o[4:0]};

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_wake_off;
      (wake_cfg_o[7:2] == 6'h00) [*3];
   endsequence
   sequence s_commit;
      $changed(wake_cfg_o) || $changed(irq_cfg_o);
   endsequence

   rst_vals_a: assert property ($past(rst_i) |-> wake_cfg_o == WAKE_CFG_RST
      && irq_cfg_o == IRQ_CFG_RST && !serial_fault_o) else $error("bad reset value");
   pulse_len_a: assert property ($stable(irq_cfg_o) |-> int_pulse_len_o ==
      (irq_cfg_o[IRQ_DUR_BIT] ? SHORT_CYC : LONG_CYC)) else $error("bad pulse length");
   io_group_a: assert property (!$past(rst_i) |-> io_group_flag_o == |$past(io_open))
      else $error("bad group flag");
   int_gate_a: assert property (!$past(rst_i) |-> int_request_o ==
      (!$past(irq_cfg_o[IRQ_ALL_BIT]) && (|$past(src_open) || |$past(io_open))))
      else $error("bad interrupt request");
   inh_all_a: assert property (irq_cfg_o[IRQ_ALL_BIT] [*2] |-> !int_request_o)
      else $error("request despite inhibit all");
   wake_off_a: assert property (s_wake_off |-> !wake_event_o)
      else $error("wake without enabled edge");
   commit_gap_a: assert property (s_commit |-> spi_cs_n_i && !$rose(serial_fault_o))
      else $error("register changed at wrong time");
   miso_en_a: assert property (spi_miso_oe_n_o == spi_cs_n_i)
      else $error("miso enable wrong");
endmodule : wake_cfg_chk

bind wake_and_irq_mask_config wake_cfg_chk #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) u_chk
(
   .sys_clk_i, .rst_i, .spi_cs_n_i, .spi_miso_oe_n_o, .io_event_i, .irq_src_i, .wake_cfg_o,
   .irq_cfg_o, .wake_event_o, .io_group_flag_o, .int_request_o, .int_pulse_len_o,
   .serial_fault_o
);

// ==== test/spi_master_model.sv ====
`timescale 1ns/10ps
module spi_master_model
(
   output logic spi_sck_o,
   output logic spi_cs_n_o,
   output logic spi_mosi_o,
   input wire logic spi_miso_i
);
   initial
   begin
      spi_sck_o = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_mosi_o = 1'b1;
   end

   task automatic xfer(input logic [15:0] tx, input int hns, output logic [15:0] rx);
      #7;
      spi_cs_n_o = 1'b0;
      for (int k = 15; k >= 0; k--)
      begin
         spi_mosi_o = tx[k];
         #(hns);
         rx[k] = spi_miso_i;
         spi_sck_o = 1'b1;
         #(hns);
         spi_sck_o = 1'b0;
      end
      spi_cs_n_o = 1'b1;
      // Released line shows no stale bit
      spi_mosi_o = ~tx[0];
   endtask : xfer
endmodule : spi_master_model

// ==== test/wake_and_irq_mask_config_tb_top.sv ====
`timescale 1ns/10ps
module wake_and_irq_mask_config_tb_top
   import wake_cfg_pkg::*;
   ;
   localparam int LC = 40;
   localparam int SC = 10;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic sck, cs_n, mosi, miso, oe_n, wev, grp, req, flt;
   logic [7:0] flags = 8'h5a;
   logic [2:0] lvl = 3'h0;
   logic [3:0] ev = 4'h0;
   irq_src_s src = '0;
   logic [7:0] wcfg, icfg;
   logic [15:0] plen, rx;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;

   always #2.5 sys_clk_i = ~sys_clk_i;

   spi_master_model u_mst (.spi_sck_o(sck), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi),
      .spi_miso_i(miso));
   wake_and_irq_mask_config #(.LONG_CYC(LC), .SHORT_CYC(SC)) u_dut (.sys_clk_i(sys_clk_i),
      .rst_i(rst_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
      .spi_miso_oe_n_o(oe_n), .global_flags_i(flags), .io_level_i(lvl), .io_event_i(ev),
      .irq_src_i(src), .wake_cfg_o(wcfg), .irq_cfg_o(icfg), .wake_event_o(wev),
      .io_group_flag_o(grp), .int_request_o(req), .int_pulse_len_o(plen),
      .serial_fault_o(flt));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic complete_run();
      if (n_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic tk(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask : tk

   task automatic send(input logic [6:0] c, input logic [7:0] d, input logic ok, input int h);
      u_mst.xfer({c, (~^{c, d}) ^ !ok, d}, h, rx);
      tk(20);
   endtask : send

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_wake_rw();
      logic [7:0] d;
      logic [7:0] old;
      for (int c = 0; c < 4; c++)
      begin
         d = {c[1:0], ~c[1:0], c[1:0], c[1:0]};
         old = wcfg;
         send(CMD_WR_WAKE, d, 1'b1, 16);
         chk("wr_answer", {flags, old}, rx);
         chk("wake_cfg", {8'h00, d}, {8'h00, wcfg});
         send(CMD_RD_WAKE, 8'h00, 1'b1, 16);
         chk("wake_read", {flags, d}, rx);
      end
   endtask : t_wake_rw

   task automatic t_wake_edge();
      int n;
      for (int ln = 0; ln < 3; ln++)
      begin
         for (int m = 0; m < 4; m++)
         begin
            send(CMD_WR_WAKE, 8'({m[1:0], 6'h00} >> (2 * ln)), 1'b1, 16);
            for (int v = 1; v >= 0; v--)
            begin
               n = 0;
               lvl[ln] = v[0];
               repeat (12)
               begin
                  @(negedge sys_clk_i);
                  n += (wev === 1'b1);
               end
               chk("wake_pulses", 16'(v ? m % 2 : m / 2), 16'(n));
            end
         end
      end
   endtask : t_wake_edge

   task automatic t_mask();
      logic e;
      for (int mk = 0; mk < 4; mk++)
      begin
         send(CMD_WR_WAKE, {6'h00, mk[1:0]}, 1'b1, 16);
         for (int b = 0; b < 4; b++)
         begin
            ev = 4'(1 << b);
            tk(1);
            ev = 4'h0;
            e = !(b >= 2 ? mk[0] : mk[1]);
            chk("group_flag", {15'h0, e}, {15'h0, grp});
            chk("io_request", {15'h0, e}, {15'h0, req});
         end
      end
   endtask : t_mask

   task automatic t_irq();
      logic [7:0] cfg;
      logic e;
      send(CMD_WR_WAKE, 8'h00, 1'b1, 16);
      for (int cb = 0; cb < 8; cb++)
      begin
         cfg = 8'(1 << cb);
         send(CMD_WR_IRQ, cfg, 1'b1, 16);
         chk("irq_cfg", {8'h00, cfg}, {8'h00, icfg});
         chk("pulse_len", 16'(cfg[7] ? SC : LC), plen);
         send(CMD_RD_IRQ, 8'h00, 1'b1, 16);
         chk("irq_read", {flags, cfg}, rx);
         for (int s = 0; s < 7; s++)
         begin
            if (s == 6)
               ev = 4'h2;
            else
               src = 6'(1 << s);
            tk(1);
            ev = 4'h0;
            src = '0;
            e = !cfg[IRQ_ALL_BIT] && (s == 6 || !cfg[s == 5 ? 6 : s]);
            chk("src_request", {15'h0, e}, {15'h0, req});
         end
      end
   endtask : t_irq

   task automatic t_parity();
      send(CMD_WR_WAKE, 8'h3c, 1'b1, 16);
      send(CMD_WR_WAKE, 8'hc3, 1'b0, 16);
      chk("bad_par_keep", 16'h003c, {8'h00, wcfg});
      chk("fault_set", 16'h0001, {15'h0, flt});
      send(CMD_RD_WAKE, 8'h00, 1'b1, 16);
      chk("fault_read", {flags | 8'h80, 8'h3c}, rx);
      chk("fault_clear", 16'h0000, {15'h0, flt});
      chk("miso_oe_idle", 16'h0001, {15'h0, oe_n});
   endtask : t_parity

   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         complete_run();
      end
   end

   initial
   begin
      tk(12);
      rst_i = 1'b0;
      tk(6);
      chk("wake_rst", {8'h00, WAKE_CFG_RST}, {8'h00, wcfg});
      chk("irq_rst", {8'h00, IRQ_CFG_RST}, {8'h00, icfg});
      chk("len_rst", 16'(LC), plen);
      t_wake_rw();
      t_wake_edge();
      t_mask();
      t_irq();
      t_parity();
      complete_run();
   end
endmodule : wake_and_irq_mask_config_tb_top
